// ===== motor_pwm_time_base_tb_top.sv
// self-checking bench of the motor pwm time base
`timescale 1ns/100ps
module motor_pwm_time_base_tb_top;
   logic             core_clk  = 1'b0;     // 10 MHz
   logic             rst_n     = 1'b0;
   logic [3:0]       reg_addr  = 4'h0;
   logic [15:0]      reg_wdata = 16'h0000;
   logic             reg_wr    = 1'b0;
   logic             reg_rd    = 1'b0;
   logic             clr       = 1'b0;     // partner window clear
   logic [15:0]      reg_rdata;
   logic             tb_event_pulse;
   logic [2:0]       hi;                   // high outputs
   logic [2:0]       lo;                   // low outputs
   logic [2:0][15:0] on_cnt;
   logic [15:0]      shoot_cnt;
   logic [15:0]      q;
   logic [15:0]      q2;
   int               g;
   int               gu;                   // up/down event gap
   int               error_cnt = 0;
   int               n_tests   = 0;

   mpt_time_base mpt_time_base_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tb_event_pulse(tb_event_pulse), .pair1_high_out(hi[0]), .pair1_low_out(lo[0]),
      .pair2_high_out(hi[1]), .pair2_low_out(lo[1]), .pair3_high_out(hi[2]),
      .pair3_low_out(lo[2]));
   mpt_gate_drv mpt_gate_drv_i (.core_clk(core_clk), .clr(clr), .hi_on(hi), .lo_on(lo),
      .on_cnt(on_cnt), .shoot_cnt(shoot_cnt));

   initial
   begin
      forever #50 core_clk = ~core_clk;
   end

   // ----------------------------------------
   // bus cycles and comparisons
   // ----------------------------------------
   // bus tasks are entered just after a rising edge
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
      @(posedge core_clk);
   endtask
   // write then read with no gap
   task automatic wrrd(input logic [3:0] a, input logic [15:0] v, output logic [15:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
      @(posedge core_clk);
   endtask
   task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] s);
      n_tests++;
      if (s !== e)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   // stop, zero the count, then run with a new setup
   task automatic start(input logic [15:0] cfg);
      wr(mpt_pkg::REG_CTRL, 16'h0000);
      wr(mpt_pkg::REG_CNT, 16'h0000);
      wr(mpt_pkg::REG_CTRL, 16'h8000 | cfg);
   endtask
   // gap between two events: 0 if none, lim if only one
   task automatic ev_gap(input int lim, output int gap);
      int n;
      n = 0;
      gap = 0;
      do @(negedge core_clk); while (tb_event_pulse !== 1'b1 && ++n < lim);
      if (n < lim)
         do
         begin
            @(negedge core_clk);
            gap++;
         end
         while (tb_event_pulse !== 1'b1 && gap < lim);
      @(posedge core_clk);
   endtask
   // partner counts over n whole cycles
   task automatic window(input int n);
      clr <= 1'b1;
      @(posedge core_clk);
      clr <= 1'b0;
      repeat (n) @(posedge core_clk);
      // counts are read settled, off the edge
      @(negedge core_clk);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // hang guard, far beyond the thousand or so cycles of the tests
   initial
   begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      conclude();
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      for (int i = 0; i < 8; i++)
      begin
         rd(4'(i), q);
         chk16("reset word", 16'h0000, q);
      end
      chk16("reset pairs", 16'h0007, 16'({hi, lo}));
      $display("done reset");
      wr(mpt_pkg::REG_CTRL, 16'h8000);
      ev_gap(30, g);
      chk16("zero period events", 16'h0000, 16'(g));
      wr(mpt_pkg::REG_PER, 16'h0002);
      ev_gap(30, g);
      chk16("no reload while zero", 16'h0000, 16'(g));
      rd(mpt_pkg::REG_CNT, q);
      chk16("zero period count", 16'h0000, q);
      $display("done zero period");
      for (int ps = 0; ps < 4; ps++)
      begin
         start(16'(ps << 2));
         ev_gap(500, g);
         chk16("prescaled gap", 16'(3 << (2 * ps)), 16'(g));
      end
      start(16'h0020);
      ev_gap(100, g);
      chk16("postscaled gap", 16'h0009, 16'(g));
      $display("done free running");
      start(16'h0021);
      ev_gap(40, g);
      chk16("single second event", 16'h0028, 16'(g));
      rd(mpt_pkg::REG_CTRL, q);
      chk16("single run cleared", 16'h0021, q);
      rd(mpt_pkg::REG_CNT, q);
      chk16("single count", 16'h0000, q);
      $display("done single shot");
      start(16'h0002);
      ev_gap(100, gu);
      chk16("updown period", 16'h0006, 16'(gu));
      start(16'h0012);
      ev_gap(100, g);
      chk16("updown postscaled", 16'(2 * gu), 16'(g));
      start(16'h0013);
      ev_gap(100, g);
      chk16("double gap", 16'(gu), 16'(2 * g));
      wr(mpt_pkg::REG_PER, 16'h0064);
      start(16'h0002);
      repeat (150) @(posedge core_clk);
      rd(mpt_pkg::REG_CNT, q);
      chk16("count down flag", 16'h0001, 16'(q[15]));
      $display("done up down");
      wr(mpt_pkg::REG_PER, 16'h0009);
      wr(mpt_pkg::REG_DUTY1, 16'h0000);
      wr(mpt_pkg::REG_DUTY2, 16'h0004);
      wr(mpt_pkg::REG_DUTY3, 16'h0014);
      start(16'h0000);
      ev_gap(30, g);
      chk16("edge period", 16'h000A, 16'(g));
      window(10);
      chk16("duty zero", 16'h0000, on_cnt[0]);
      chk16("duty four", 16'h0004, on_cnt[1]);
      chk16("duty above", 16'h000A, on_cnt[2]);
      ev_gap(30, g);
      wr(mpt_pkg::REG_DUTY2, 16'h0003);
      wr(mpt_pkg::REG_PER, 16'h0005);
      ev_gap(30, g);
      chk16("period reload", 16'h0006, 16'(g));
      window(6);
      chk16("duty reload", 16'h0003, on_cnt[1]);
      chk16("leg shorts", 16'h0000, shoot_cnt);
      $display("done outputs");
      @(posedge core_clk);
      wr(mpt_pkg::REG_CTRL, 16'h0000);
      rd(mpt_pkg::REG_CNT, q);
      repeat (10) @(posedge core_clk);
      rd(mpt_pkg::REG_CNT, q2);
      chk16("stopped count held", q, q2);
      rd(mpt_pkg::REG_STAT, q);
      chk16("event flag", 16'h0001, q);
      wr(mpt_pkg::REG_STAT, 16'h0001);
      rd(mpt_pkg::REG_STAT, q);
      chk16("event flag cleared", 16'h0000, q);
      wrrd(mpt_pkg::REG_CNT, 16'h8005, q);
      chk16("counter write", 16'h0005, q);
      $display("done registers");
      conclude();
   end
endmodule

bind mpt_time_base mpt_checker mpt_checker_i (.core_clk(core_clk), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .tb_event_pulse(tb_event_pulse),
   .pair1_high_out(pair1_high_out), .pair1_low_out(pair1_low_out),
   .pair2_high_out(pair2_high_out), .pair2_low_out(pair2_low_out),
   .pair3_high_out(pair3_high_out), .pair3_low_out(pair3_low_out));

// ===== mpt_checker.sv
// port assertions of the motor pwm time base
`timescale 1ns/100ps
module mpt_checker
(
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rst_n,
   // register port
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // event and switch pairs
   input wire logic        tb_event_pulse,
   input wire logic        pair1_high_out,
   input wire logic        pair1_low_out,
   input wire logic        pair2_high_out,
   input wire logic        pair2_low_out,
   input wire logic        pair3_high_out,
   input wire logic        pair3_low_out
);
   // ----------------------------------------
   // shadows of software writes
   // ----------------------------------------
   logic       run_sh;  // misses the single-shot clear, so locks stay safe
   logic [1:0] mode_sh; // last mode written
   logic       per_z;   // period buffer zero
   logic       duty_z;  // first duty buffer zero
   logic       zlock;   // active period known zero
   logic       dlock;   // first active duty known zero
   wire        wr_ctl = reg_wr && reg_addr == mpt_pkg::REG_CTRL;
   wire        wr_per = reg_wr && reg_addr == mpt_pkg::REG_PER;
   wire        wr_dut = reg_wr && reg_addr == mpt_pkg::REG_DUTY1;

   // zlock follows the buffer only while stopped; dlock can also clear while running
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         {run_sh, mode_sh, per_z, duty_z, zlock, dlock} <= 7'h0F;
      else
      begin
         if (wr_ctl)
            {run_sh, mode_sh} <= {reg_wdata[15], reg_wdata[1:0]};
         if (wr_per)
            per_z <= reg_wdata[14:0] == 15'h0000;
         if (wr_dut)
            duty_z <= reg_wdata == 16'h0000;
         if (!run_sh)
            zlock <= per_z;
         dlock <= run_sh ? dlock && duty_z : duty_z;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   pair_compl_a: assert property (
      {pair1_low_out, pair2_low_out, pair3_low_out} ==
      ~{pair1_high_out, pair2_high_out, pair3_high_out})
      else $error("low output not complement of high");
   event_gap_a: assert property (tb_event_pulse |=> !tb_event_pulse)
      else $error("events in adjacent cycles");
   reset_quiet_a: assert property ($rose(rst_n) |-> !tb_event_pulse &&
      !pair1_high_out && !pair2_high_out && !pair3_high_out && reg_rdata == 16'h0000)
      else $error("outputs not idle after reset");
   stop_quiet_a: assert property (!run_sh && !$past(run_sh) |-> !tb_event_pulse)
      else $error("event while stopped");
   zero_per_a: assert property (
      zlock && $past(zlock) && $past(zlock, 2) |-> !tb_event_pulse)
      else $error("event with zero period");
   zero_duty_a: assert property (
      dlock && $past(dlock) && $past(dlock, 2) |-> !pair1_high_out)
      else $error("output on with zero duty");
   single_once_a: assert property (
      mode_sh == mpt_pkg::MODE_SINGLE && tb_event_pulse |=> !tb_event_pulse [*2])
      else $error("second single-shot event");
   cnt_write_a: assert property (
      reg_wr && reg_addr == mpt_pkg::REG_CNT && !run_sh ##1
      reg_rd && reg_addr == mpt_pkg::REG_CNT |=>
      reg_rdata[14:0] == $past(reg_wdata[14:0], 2))
      else $error("counter write not read back");

   ev_c: cover property (tb_event_pulse);
   single_c: cover property (mode_sh == mpt_pkg::MODE_SINGLE && tb_event_pulse);
   double_c: cover property (mode_sh == mpt_pkg::MODE_DOUBLE && tb_event_pulse);
endmodule

// ===== mpt_gate_drv.sv
// behavioural gate drivers of the three bridge legs
`timescale 1ns/100ps
module mpt_gate_drv
(
   // clock and window clear
   input  wire logic             core_clk,
   input  wire logic             clr,
   // gate commands
   input  wire logic [2:0]       hi_on,
   input  wire logic [2:0]       lo_on,
   // conduction and short counts
   output logic      [2:0][15:0] on_cnt,
   output logic      [15:0]      shoot_cnt
);
   // ----------------------------------------
   // conduction per window
   // ----------------------------------------
   // high switch on-time, cleared per window
   always_ff @(posedge core_clk)
   begin
      for (int i = 0; i < 3; i++)
         on_cnt[i] <= clr ? 16'h0000 : on_cnt[i] + 16'(hi_on[i]);
   end
   // both switches of a leg on would short the supply
   always_ff @(posedge core_clk)
      shoot_cnt <= clr ? 16'h0000 : shoot_cnt + 16'(|(hi_on & lo_on));
endmodule

// ===== mpt_pkg.sv
// constants, register layout and types of the motor pwm time base
package mpt_pkg;

   // ------------------------------------------------------------
   // register bus geometry and word indices
   // ------------------------------------------------------------
   localparam int          ADDR_W    = 4;
   localparam int          DATA_W    = 16;
   localparam int          CNT_W     = 15;
   localparam int          NUM_GEN   = 3;
   localparam logic [3:0]  REG_CTRL  = 4'h0;
   localparam logic [3:0]  REG_CNT   = 4'h1;
   localparam logic [3:0]  REG_PER   = 4'h2;
   localparam logic [3:0]  REG_DUTY1 = 4'h3;
   localparam logic [3:0]  REG_DUTY2 = 4'h4;
   localparam logic [3:0]  REG_DUTY3 = 4'h5;
   localparam logic [3:0]  REG_STAT  = 4'h6;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int          DIR_BIT   = 15;
   localparam int          FLAG_BIT  = 0;
   localparam logic [14:0] CNT_ZERO  = 15'h0000;
   localparam logic [14:0] CNT_ONE   = 15'h0001;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [14:0] PER_RST   = 15'h0000;
   localparam logic [3:0]  POST_ZERO = 4'h0;
   localparam logic [3:0]  POST_ONE  = 4'h1;
   localparam logic [5:0]  PRE_ZERO  = 6'h00;
   localparam logic [5:0]  PRE_ONE   = 6'h01;
   localparam logic [5:0]  PRE_DIV1  = 6'h00;
   localparam logic [5:0]  PRE_DIV4  = 6'h03;
   localparam logic [5:0]  PRE_DIV16 = 6'h0F;
   localparam logic [5:0]  PRE_DIV64 = 6'h3F;

   // ------------------------------------------------------------
   // modes and prescale codes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_FREE   = 2'h0,
      MODE_SINGLE = 2'h1,
      MODE_UPDN   = 2'h2,
      MODE_DOUBLE = 2'h3
   } mpt_mode_e;

   // control word: run bit 15, postscale 7:4, prescale 3:2, mode 1:0
   typedef struct packed {
      logic       time_base_run;
      logic [6:0] rsvd;
      logic [3:0] postscale_sel;
      logic [1:0] prescale_sel;
      mpt_mode_e  time_base_mode_sel;
   } mpt_ctrl_s;

   localparam mpt_ctrl_s CTRL_RST = '{1'b0, 7'h00, 4'h0, 2'h0, MODE_FREE};

   // register port request
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } mpt_req_s;

endpackage

// ===== mpt_time_base.sv
// motor pwm time base with edge and up/down duty outputs
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/100ps
module mpt_time_base
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // time base event
   output logic             tb_event_pulse,
   // power switch pairs
   output logic             pair1_high_out,
   output logic             pair1_low_out,
   output logic             pair2_high_out,
   output logic             pair2_low_out,
   output logic             pair3_high_out,
   output logic             pair3_low_out
);

   // ------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------

   // terminal count of the prescaler for each divide code
   function automatic logic [5:0] presc_limit(input logic [1:0] sel);
      logic [5:0] lim;
      lim = mpt_pkg::PRE_DIV1;
      case (sel)
         2'h1:    lim = mpt_pkg::PRE_DIV4;
         2'h2:    lim = mpt_pkg::PRE_DIV16;
         2'h3:    lim = mpt_pkg::PRE_DIV64;
         default: lim = mpt_pkg::PRE_DIV1;
      endcase
      return lim;
   endfunction

   // edge-aligned compare: on while counter below duty
   function automatic logic duty_on(input logic [15:0] duty,
                                    input logic [14:0] cnt);
      return (duty > {1'b0, cnt});
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   mpt_pkg::mpt_ctrl_s ctrl;                   // control word
   logic [14:0]        cnt;                    // time base count
   logic               dir_down;               // count direction
   logic [14:0]        per_buf;                // software period
   logic [14:0]        per_act;                // active period
   logic [15:0]        duty_buf [3];           // software duties
   logic [15:0]        duty_act [3];           // active duties
   logic [5:0]         presc;                  // prescaler count
   logic [3:0]         post;                   // postscaler count
   logic               flag;                   // sticky event flag

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   mpt_pkg::mpt_req_s req;
   assign req = '{reg_addr, reg_wdata, reg_wr, reg_rd};

   wire wr_ctrl  = req.wr && (req.addr == mpt_pkg::REG_CTRL);
   wire wr_cnt   = req.wr && (req.addr == mpt_pkg::REG_CNT);
   wire wr_per   = req.wr && (req.addr == mpt_pkg::REG_PER);
   wire wr_stat  = req.wr && (req.addr == mpt_pkg::REG_STAT);
   wire wr_duty1 = req.wr && (req.addr == mpt_pkg::REG_DUTY1);
   wire wr_duty2 = req.wr && (req.addr == mpt_pkg::REG_DUTY2);
   wire wr_duty3 = req.wr && (req.addr == mpt_pkg::REG_DUTY3);
   wire [2:0] wr_duty = {wr_duty3, wr_duty2, wr_duty1};

   // prescaler and postscaler restart on either write
   wire scale_clr = wr_ctrl || wr_cnt;

   // ------------------------------------------------------------
   // time base decode
   // ------------------------------------------------------------
   wire mpt_pkg::mpt_mode_e mode = ctrl.time_base_mode_sel;
   wire run       = ctrl.time_base_run;
   wire updn_mode = (mode == mpt_pkg::MODE_UPDN) ||
                    (mode == mpt_pkg::MODE_DOUBLE);
   wire per_zero  = (per_act == mpt_pkg::PER_RST);
   wire at_zero   = (cnt == mpt_pkg::CNT_ZERO);
   wire at_match  = (cnt == per_act);

   // counter clock: instruction clock through the prescaler
   wire presc_end = (presc == presc_limit(ctrl.prescale_sel));

   // zero period freezes the counter and all events
   wire tick      = run && presc_end && !per_zero;

   // edge modes wrap on match; up/down reverses on match
   wire edge_wrap = tick && !updn_mode && at_match;
   wire turn_down = tick && updn_mode && !dir_down && at_match;
   wire turn_up   = tick && updn_mode && dir_down && at_zero;

   // raw event per mode before postscaling
   wire ev_free   = edge_wrap && (mode == mpt_pkg::MODE_FREE);
   wire ev_single = edge_wrap && (mode == mpt_pkg::MODE_SINGLE);
   wire ev_updn   = turn_up && (mode == mpt_pkg::MODE_UPDN);
   wire ev_double = (mode == mpt_pkg::MODE_DOUBLE) &&
                    (turn_up || turn_down);

   // postscaler counts only in free-running and up/down
   wire ev_scaled = ev_free || ev_updn;
   wire post_end  = (post == ctrl.postscale_sel);
   wire next_event = (ev_scaled && post_end) ||
                     ev_single || ev_double;

   // period reload: wrap, zero in up/down, or stopped
   wire per_load  = !run || edge_wrap || turn_up;

   // duty reload: wrap, zero, match in double mode, stopped
   wire duty_load = !run || edge_wrap || turn_up ||
                    (turn_down && (mode == mpt_pkg::MODE_DOUBLE));

   // ------------------------------------------------------------
   // next counter value
   // ------------------------------------------------------------
   logic [14:0] next_cnt;
   logic        next_dir;

   // one step per tick; software write overrides the step
   always_comb
   begin
      next_cnt = cnt;
      next_dir = dir_down && updn_mode;                           // edge modes count up
      if (wr_cnt)
      begin
         // direction stays read-only
         next_cnt = req.wdata[14:0];
      end
      else if (edge_wrap)
      begin
         next_cnt = mpt_pkg::CNT_ZERO;
      end
      else if (turn_down)
      begin
         // peak held one tick, so each half spans per+1 ticks
         next_dir = 1'b1;
         next_cnt = cnt;
      end
      else if (turn_up)
      begin
         next_dir = 1'b0;
         next_cnt = cnt;
      end
      else if (tick)
      begin
         // plain step in the current direction
         next_cnt = next_dir ? cnt - mpt_pkg::CNT_ONE
                             : cnt + mpt_pkg::CNT_ONE;
      end
   end

   // ------------------------------------------------------------
   // output compare
   // ------------------------------------------------------------
   logic [2:0] next_high;

   // both alignments reduce to a below-duty compare; in up/down
   // a count equal to duty is off in both directions, on only below it
   always_comb
   begin
      next_high = 3'h0;
      for (int i = 0; i < mpt_pkg::NUM_GEN; i++)
      begin
         if (updn_mode)
         begin
            // duty equal to period keeps it on all period
            next_high[i] = duty_on(duty_act[i], next_cnt) ||
                           (duty_act[i] == {1'b0, per_act} &&
                            duty_act[i] != mpt_pkg::WORD_ZERO);
         end
         else
         begin
            // duty zero stays off, above period stays on
            next_high[i] = duty_on(duty_act[i], next_cnt);
         end
      end
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   logic [15:0] next_rdata;

   // unmapped indices read zero
   always_comb
   begin
      next_rdata = mpt_pkg::WORD_ZERO;
      if (req.addr == mpt_pkg::REG_CTRL)
      begin
         next_rdata = ctrl;
      end
      else if (req.addr == mpt_pkg::REG_CNT)
      begin
         next_rdata = {dir_down, cnt};
      end
      else if (req.addr == mpt_pkg::REG_PER)
      begin
         next_rdata = {1'b0, per_buf};
      end
      else if (req.addr == mpt_pkg::REG_DUTY1)
      begin
         next_rdata = duty_buf[0];
      end
      else if (req.addr == mpt_pkg::REG_DUTY2)
      begin
         next_rdata = duty_buf[1];
      end
      else if (req.addr == mpt_pkg::REG_DUTY3)
      begin
         next_rdata = duty_buf[2];
      end
      else if (req.addr == mpt_pkg::REG_STAT)
      begin
         next_rdata = {15'h0000, flag};
      end
   end

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------

   // hardware clears run at the end of a single shot; a
   // software write in the same cycle takes precedence
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl <= mpt_pkg::CTRL_RST;
      else if (wr_ctrl)
         ctrl <= {req.wdata[15], 7'h00, req.wdata[7:0]};
      else if (ev_single)
         ctrl.time_base_run <= 1'b0;
   end

   // ------------------------------------------------------------
   // counter and direction
   // ------------------------------------------------------------

   // clearing run only stops ticks; count is kept
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt      <= mpt_pkg::CNT_ZERO;
         dir_down <= 1'b0;
      end
      else
      begin
         cnt      <= next_cnt;
         dir_down <= next_dir;
      end
   end

   // ------------------------------------------------------------
   // prescaler
   // ------------------------------------------------------------

   // free-runs so the first tick after enable is one full
   // prescale away from the last clear
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         presc <= mpt_pkg::PRE_ZERO;
      else if (scale_clr || presc_end)
         presc <= mpt_pkg::PRE_ZERO;
      else
         presc <= presc + mpt_pkg::PRE_ONE;
   end

   // ------------------------------------------------------------
   // postscaler
   // ------------------------------------------------------------

   // restarts after every flagged free-running or up/down event
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         post <= mpt_pkg::POST_ZERO;
      else if (scale_clr)
         post <= mpt_pkg::POST_ZERO;
      else if (ev_scaled && post_end)
         post <= mpt_pkg::POST_ZERO;
      else if (ev_scaled)
         post <= post + mpt_pkg::POST_ONE;
   end

   // ------------------------------------------------------------
   // event pulse and sticky flag
   // ------------------------------------------------------------

   // write one clears the flag; a new event wins the same cycle
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tb_event_pulse <= 1'b0;
         flag           <= 1'b0;
      end
      else
      begin
         tb_event_pulse <= next_event;
         if (next_event)
            flag <= 1'b1;
         else if (wr_stat && req.wdata[mpt_pkg::FLAG_BIT])
            flag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // period buffer and active period
   // ------------------------------------------------------------

   // a zero active period is only replaced while stopped
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         per_buf <= mpt_pkg::PER_RST;
         per_act <= mpt_pkg::PER_RST;
      end
      else
      begin
         if (wr_per)
            per_buf <= req.wdata[14:0];
         if (per_load)
            per_act <= per_buf;
      end
   end

   // ------------------------------------------------------------
   // duty buffers and active duties
   // ------------------------------------------------------------

   // active copy only moves at period boundaries, at the peak in double mode
   // or while stopped, so a write mid-period never glitches an output
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < mpt_pkg::NUM_GEN; i++)
         begin
            duty_buf[i] <= mpt_pkg::WORD_ZERO;
            duty_act[i] <= mpt_pkg::WORD_ZERO;
         end
      end
      else
      begin
         for (int i = 0; i < mpt_pkg::NUM_GEN; i++)
         begin
            if (wr_duty[i])
               duty_buf[i] <= req.wdata;
            if (duty_load)
               duty_act[i] <= duty_buf[i];
         end
      end
   end

   // ------------------------------------------------------------
   // outputs and read data
   // ------------------------------------------------------------

   // low side is the exact complement of the high side
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pair1_high_out <= 1'b0;
         pair1_low_out  <= 1'b1;
         pair2_high_out <= 1'b0;
         pair2_low_out  <= 1'b1;
         pair3_high_out <= 1'b0;
         pair3_low_out  <= 1'b1;
         reg_rdata      <= mpt_pkg::WORD_ZERO;
      end
      else
      begin
         pair1_high_out <= next_high[0];
         pair1_low_out  <= ~next_high[0];
         pair2_high_out <= next_high[1];
         pair2_low_out  <= ~next_high[1];
         pair3_high_out <= next_high[2];
         pair3_low_out  <= ~next_high[2];
         reg_rdata      <= req.rd ? next_rdata : mpt_pkg::WORD_ZERO;
      end
   end

endmodule
